//--- reset_seq_pkg.sv
// Constants and types shared by the reset initialization sequencer
`default_nettype none
package reset_seq_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS        = 8000;
  localparam int RESET_IN_MIN_PERIODS = 32;
  localparam int RESET_OUT_MIN_PERIODS = 512;
  localparam int HARD_TO_SOFT_PERIODS = 16;
  localparam int STRAP_SETUP_PERIODS  = 4;
  localparam int STRAP_RESUME_PERIODS = 1;
  localparam int STRAP_OFF_MAX_PS     = 4000;
  localparam int STRAP_OFF_CYCLES     = (STRAP_OFF_MAX_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                        (STRAP_OFF_MAX_PS / CLK_PERIOD_PS);
  localparam int PLL_LOCK_US          = 100;
  localparam int PLL_LOCK_CYCLES      = (PLL_LOCK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DLL_LOCK_MIN_CYCLES  = 7680;
  localparam int DLL_LOCK_MAX_CYCLES  = 122880;
  localparam int DLL_MIN_RATIO        = 2;

  // ----------------------------------------
  // Strap layout, reset values and sequencer states
  // ----------------------------------------
  localparam int BOOT_SRC_W           = 3;
  localparam logic [2:0] BOOT_SRC_RST = 3'h0;
  localparam logic [3:0] DLL_RATIO_RST = 4'h2;

  typedef enum logic [2:0] {
    ST_POR      = 3'b000,
    ST_PLL_WAIT = 3'b001,
    ST_DLL_WAIT = 3'b011,
    ST_HARD_OUT = 3'b010,
    ST_SOFT_OUT = 3'b110,
    ST_RUN      = 3'b111
  } seq_state_t;

endpackage : reset_seq_pkg
`default_nettype wire

//--- pulse_filter.sv
// Minimum-width qualifier for a synchronised active-level input
`default_nettype none
module pulse_filter
  import reset_seq_pkg::*;
#(
  parameter int MIN_PERIODS = 32
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic level_in,
  output var  logic qualified
);

  logic [$clog2(MIN_PERIODS+1)-1:0] cnt_ff;

  // Counts periods of the tick input only; a short glitch restarts the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (!level_in) begin
      cnt_ff <= '0;
    end else if (tick && cnt_ff != MIN_PERIODS[$bits(cnt_ff)-1:0]) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign qualified = level_in && (cnt_ff == MIN_PERIODS[$bits(cnt_ff)-1:0]);

endmodule : pulse_filter
`default_nettype wire

//--- reset_init_sequencer.sv
// Reset initialization sequencer: input qualification, strap capture, lock waits, reset-out ordering
`default_nettype none
module reset_init_sequencer
  import reset_seq_pkg::*;
#(
  parameter int PLL_WAIT_CYCLES = PLL_LOCK_CYCLES,
  parameter int DLL_UNIT_CYCLES = DLL_LOCK_MIN_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  host_mode,
  input  wire logic                  primary_clock_tick,
  input  wire logic                  bus_sync_tick,
  input  wire logic                  power_on_reset_line_n,
  input  wire logic                  hard_reset_line_in,
  input  wire logic                  soft_reset_line_in,
  input  wire logic [BOOT_SRC_W-1:0] boot_source_in,
  input  wire logic                  input_clock_divide_select,
  input  wire logic [3:0]            dll_ratio,
  output logic                       hard_reset_line_out,
  output logic                       hard_reset_line_oe,
  output logic                       soft_reset_line_out,
  output logic                       soft_reset_line_oe,
  output logic                       strap_oe,
  output logic [BOOT_SRC_W-1:0]      boot_source,
  output logic                       clock_divide_latched,
  output logic                       internal_reset,
  output logic                       pll_locked,
  output logic                       dll_locked,
  output logic                       bus_tick
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [6:0] sync1_ff;
  logic [6:0] sync2_ff;
  logic [6:0] pins;

  assign pins = {power_on_reset_line_n, hard_reset_line_in, soft_reset_line_in,
                 boot_source_in, input_clock_divide_select};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 7'h3F;
      sync2_ff <= 7'h3F;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  logic por_asserted;
  logic hard_low;
  logic soft_low;
  assign por_asserted = !sync2_ff[6];
  assign hard_low     = !sync2_ff[5];
  assign soft_low     = !sync2_ff[4];

  // ----------------------------------------
  // Reference and bus-sync rates
  // ----------------------------------------
  logic ref_tick;
  logic div_phase_ff;

  assign ref_tick = host_mode ? primary_clock_tick : bus_sync_tick;

  // Host mode: bus-sync rate is the primary tick, halved when the divide strap is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_phase_ff <= 1'b0;
    end else if (host_mode && primary_clock_tick) begin
      div_phase_ff <= !div_phase_ff;
    end
  end

  assign bus_tick = host_mode ?
                    (primary_clock_tick && (!clock_divide_latched || div_phase_ff)) :
                    bus_sync_tick;

  // ----------------------------------------
  // Input reset qualification
  // ----------------------------------------
  logic por_ok;
  logic hard_in_ok;
  logic soft_in_ok;
  logic own_drive;

  pulse_filter #(.MIN_PERIODS(RESET_IN_MIN_PERIODS)) u_por_filt (
    .clk      (clk),
    .rst      (rst),
    .tick     (ref_tick),
    .level_in (por_asserted),
    .qualified(por_ok)
  );

  // Our own pull-down reads back on the line; ignore it as an external request
  pulse_filter #(.MIN_PERIODS(RESET_IN_MIN_PERIODS)) u_hard_filt (
    .clk      (clk),
    .rst      (rst),
    .tick     (bus_tick),
    .level_in (hard_low && !own_drive),
    .qualified(hard_in_ok)
  );

  pulse_filter #(.MIN_PERIODS(RESET_IN_MIN_PERIODS)) u_soft_filt (
    .clk      (clk),
    .rst      (rst),
    .tick     (bus_tick),
    .level_in (soft_low && !own_drive),
    .qualified(soft_in_ok)
  );

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic [2:0] setup_cnt_ff;
  logic       straps_latched_ff;
  logic       por_seen_ff;

  // Straps must sit stable for the setup window before power-on reset lets go
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_cnt_ff <= 3'h0;
    end else if (sync2_ff[3:0] != {boot_source, clock_divide_latched} && por_asserted) begin
      setup_cnt_ff <= 3'h0;
    end else if (ref_tick && setup_cnt_ff != STRAP_SETUP_PERIODS[2:0]) begin
      setup_cnt_ff <= setup_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_source          <= BOOT_SRC_RST;
      clock_divide_latched <= 1'b0;
      straps_latched_ff    <= 1'b0;
      por_seen_ff          <= 1'b0;
    end else if (por_asserted) begin
      boot_source          <= sync2_ff[3:1];
      clock_divide_latched <= sync2_ff[0];
      straps_latched_ff    <= 1'b0;
      por_seen_ff          <= por_ok;
    end else if (por_seen_ff && !straps_latched_ff && setup_cnt_ff == STRAP_SETUP_PERIODS[2:0]) begin
      // Late strap movement delays the start until a full setup window has passed
      straps_latched_ff    <= 1'b1;
    end
  end

  // ----------------------------------------
  // Sequencing state machine
  // ----------------------------------------
  seq_state_t state_ff;
  logic [$clog2(PLL_WAIT_CYCLES+1)-1:0] pll_cnt_ff;
  logic [20:0] dll_cnt_ff;
  logic [9:0]  bus_cnt_ff;
  logic [20:0] dll_target;
  logic [3:0]  ratio_half;
  logic        restart;
  logic        hard_drive_ff;

  assign restart    = por_asserted || hard_in_ok || soft_in_ok;
  assign ratio_half = dll_ratio / 4'(DLL_MIN_RATIO);
  // Lock wait grows with the square of the ratio: one unit at 2:1, sixteen at 8:1
  assign dll_target = 21'(DLL_UNIT_CYCLES) * 21'(ratio_half) * 21'(ratio_half);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_POR;
    end else if (restart) begin
      state_ff <= ST_POR;
    end else begin
      unique case (state_ff)
        ST_POR:      if (straps_latched_ff) state_ff <= ST_PLL_WAIT;
        ST_PLL_WAIT: if (pll_cnt_ff == PLL_WAIT_CYCLES[$bits(pll_cnt_ff)-1:0]) state_ff <= ST_DLL_WAIT;
        ST_DLL_WAIT: if (dll_cnt_ff >= dll_target) state_ff <= ST_HARD_OUT;
        ST_HARD_OUT: if (bus_cnt_ff == RESET_OUT_MIN_PERIODS[9:0]) state_ff <= ST_SOFT_OUT;
        ST_SOFT_OUT: if (bus_cnt_ff == HARD_TO_SOFT_PERIODS[9:0]) state_ff <= ST_RUN;
        ST_RUN:      state_ff <= ST_RUN;
        default:     state_ff <= ST_POR;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_cnt_ff <= '0;
    end else if (state_ff != ST_PLL_WAIT || restart) begin
      pll_cnt_ff <= '0;
    end else if (pll_cnt_ff != PLL_WAIT_CYCLES[$bits(pll_cnt_ff)-1:0]) begin
      pll_cnt_ff <= pll_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dll_cnt_ff <= 21'h0;
    end else if (state_ff != ST_DLL_WAIT || restart) begin
      dll_cnt_ff <= 21'h0;
    end else if (bus_tick) begin
      dll_cnt_ff <= dll_cnt_ff + 21'h1;
    end
  end

  // Counts bus-sync periods; cleared on every state change
  // The hard-to-soft gap counts only ticks after the hard line has really been let go
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_cnt_ff <= 10'h0;
    end else if (restart || (state_ff != ST_HARD_OUT && state_ff != ST_SOFT_OUT)) begin
      bus_cnt_ff <= 10'h0;
    end else if (state_ff == ST_HARD_OUT && bus_cnt_ff == RESET_OUT_MIN_PERIODS[9:0]) begin
      bus_cnt_ff <= 10'h0;
    end else if (bus_tick && !(state_ff == ST_SOFT_OUT && hard_drive_ff)) begin
      bus_cnt_ff <= bus_cnt_ff + 10'h1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic soft_drive_ff;
  logic strap_oe_ff;
  logic resume_wait_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hard_drive_ff <= 1'b1;
      soft_drive_ff <= 1'b1;
    end else begin
      hard_drive_ff <= (state_ff != ST_SOFT_OUT && state_ff != ST_RUN) || restart;
      soft_drive_ff <= (state_ff != ST_RUN) || restart;
    end
  end

  assign own_drive           = hard_drive_ff || soft_drive_ff;
  assign hard_reset_line_out = 1'b0;
  assign soft_reset_line_out = 1'b0;
  assign hard_reset_line_oe  = hard_drive_ff;
  assign soft_reset_line_oe  = soft_drive_ff;

  // Drive straps again only after a full bus-sync period of released hard reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resume_wait_ff <= 1'b0;
      strap_oe_ff    <= 1'b0;
    end else if (hard_drive_ff || hard_low) begin
      resume_wait_ff <= 1'b0;
      strap_oe_ff    <= 1'b0;
    end else if (bus_tick && !resume_wait_ff) begin
      resume_wait_ff <= 1'b1;
    end else if (bus_tick && resume_wait_ff) begin
      strap_oe_ff    <= 1'b1;
    end
  end

  // Combinational turn-off so the drivers drop in the same cycle hard reset rises
  assign strap_oe = strap_oe_ff && !hard_drive_ff && !hard_low && !restart;

  assign internal_reset = state_ff == ST_POR || state_ff == ST_PLL_WAIT;
  assign pll_locked     = !internal_reset;
  assign dll_locked     = state_ff == ST_HARD_OUT || state_ff == ST_SOFT_OUT || state_ff == ST_RUN;

endmodule : reset_init_sequencer
`default_nettype wire

//--- reset_init_sequencer_checker.sv
// Port-level assertions for the reset initialization sequencer
`default_nettype none
module reset_init_sequencer_checker
  import reset_seq_pkg::*;
#(
  parameter int PLL_WAIT_CYCLES = 20,
  parameter int DLL_UNIT_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       host_mode,
  input wire logic       bus_sync_tick,
  input wire logic [3:0] dll_ratio,
  input wire logic       hard_reset_line_out,
  input wire logic       hard_reset_line_oe,
  input wire logic       soft_reset_line_out,
  input wire logic       soft_reset_line_oe,
  input wire logic       strap_oe,
  input wire logic       internal_reset,
  input wire logic       pll_locked,
  input wire logic       dll_locked,
  input wire logic       bus_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Saturating counters, so a long wait never wraps into a false short one
  logic [15:0] held_ff, gap_ff, ir_ff, dll_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) held_ff <= '0;
    else if (!hard_reset_line_oe) held_ff <= '0;
    else if (bus_tick && !(&held_ff)) held_ff <= held_ff + 16'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gap_ff <= '0;
    else if (hard_reset_line_oe) gap_ff <= '0;
    else if (bus_tick && !(&gap_ff)) gap_ff <= gap_ff + 16'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ir_ff <= '0;
    else if (!internal_reset) ir_ff <= '0;
    else if (!(&ir_ff)) ir_ff <= ir_ff + 16'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) dll_ff <= '0;
    else if (!pll_locked) dll_ff <= '0;
    else if (bus_tick && !(&dll_ff)) dll_ff <= dll_ff + 16'h1;
  end
  property p_out_low; hard_reset_line_out == 1'b0 && soft_reset_line_out == 1'b0; endproperty
  a_out_low: assert property (p_out_low) else $error("open drain line driven high");
  property p_hold; $fell(hard_reset_line_oe) |-> held_ff >= 16'd512; endproperty
  a_hold: assert property (p_hold) else $error("reset out held too briefly");
  property p_gap; $fell(soft_reset_line_oe) |-> !hard_reset_line_oe && gap_ff >= 16'd16; endproperty
  a_gap: assert property (p_gap) else $error("soft release too soon after hard");
  property p_strap_off; hard_reset_line_oe |-> !strap_oe; endproperty
  a_strap_off: assert property (p_strap_off) else $error("straps driven in hard reset");
  property p_strap_on; $rose(strap_oe) |-> gap_ff >= 16'd1; endproperty
  a_strap_on: assert property (p_strap_on) else $error("straps resumed too early");
  property p_pll; $fell(internal_reset) |-> ir_ff >= PLL_WAIT_CYCLES; endproperty
  a_pll: assert property (p_pll) else $error("lock wait cut short");
  property p_dll;
    $rose(dll_locked) |-> pll_locked && dll_ff >= DLL_UNIT_CYCLES * (dll_ratio >> 1) * (dll_ratio >> 1);
  endproperty
  a_dll: assert property (p_dll) else $error("delay lock wait too short");
  property p_tick; !host_mode |-> bus_tick == bus_sync_tick; endproperty
  a_tick: assert property (p_tick) else $error("agent tick not the bus sync tick");
endmodule : reset_init_sequencer_checker

bind reset_init_sequencer reset_init_sequencer_checker #(
  .PLL_WAIT_CYCLES(PLL_WAIT_CYCLES),
  .DLL_UNIT_CYCLES(DLL_UNIT_CYCLES)
) u_chk (.clk, .rst, .host_mode, .bus_sync_tick, .dll_ratio, .hard_reset_line_out, .hard_reset_line_oe,
  .soft_reset_line_out, .soft_reset_line_oe, .strap_oe, .internal_reset, .pll_locked, .dll_locked, .bus_tick);
`default_nettype wire

//--- reset_board_model.sv
// Board side: clock ticks, power-on reset stretch and open-drain pull-ups
`default_nettype none
module reset_board_model (
  input  wire logic clk,
  input  wire logic host_mode,
  input  wire logic por_req,
  input  wire logic ext_hard,
  input  wire logic ext_soft,
  input  wire logic hard_reset_line_oe,
  input  wire logic soft_reset_line_oe,
  output logic      primary_clock_tick,
  output logic      bus_sync_tick,
  output logic      power_on_reset_line_n,
  output logic      hard_reset_line_in,
  output logic      soft_reset_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pdiv_ff = '0;
  logic [1:0] sdiv_ff = '0;
  logic [5:0] por_ff = '0;
  always_ff @(posedge clk) begin
    pdiv_ff <= (pdiv_ff == 2'h2) ? 2'h0 : pdiv_ff + 2'h1;
    sdiv_ff <= sdiv_ff + 2'h1;
  end
  assign primary_clock_tick = (pdiv_ff == 2'h2);
  assign bus_sync_tick = (sdiv_ff == 2'h3);
  // Release waits 32 reference ticks after the request drops, counted on a running clock
  always_ff @(posedge clk) begin
    if (por_req) por_ff <= '0;
    else if ((host_mode ? primary_clock_tick : bus_sync_tick) && por_ff < 6'h20) por_ff <= por_ff + 6'h1;
  end
  assign power_on_reset_line_n = !por_req && por_ff == 6'h20;
  assign hard_reset_line_in = !(hard_reset_line_oe || ext_hard);
  assign soft_reset_line_in = !(soft_reset_line_oe || ext_soft);
endmodule : reset_board_model
`default_nettype wire

//--- reset_init_sequencer_test.sv
// Self-checking bench for the reset initialization sequencer
`default_nettype none
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module reset_init_sequencer_test;
  import reset_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, host_mode = 0, por_req = 1, ext_hard = 0, ext_soft = 0, input_clock_divide_select = 0;
  logic [2:0] boot_source_in = '0;
  logic [3:0] dll_ratio = 4'h2, last = '0;
  logic [3:0] exp_q[$];
  logic [3:0] exp_v = '0;
  wire logic primary_clock_tick, bus_sync_tick, power_on_reset_line_n, hard_reset_line_in, soft_reset_line_in;
  wire logic hard_reset_line_out, hard_reset_line_oe, soft_reset_line_out, soft_reset_line_oe, strap_oe;
  wire logic clock_divide_latched, internal_reset, pll_locked, dll_locked, bus_tick;
  wire logic [2:0] boot_source;
  int fails = 0, tests_run = 0, cycles = 0, gap = 0, hold = 0;
  logic pll_d = 0, hard_d = 0, soft_d = 0, dll_d = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  reset_init_sequencer #(.PLL_WAIT_CYCLES(20), .DLL_UNIT_CYCLES(4)) u_dut (.clk, .rst, .host_mode,
    .primary_clock_tick, .bus_sync_tick, .power_on_reset_line_n, .hard_reset_line_in, .soft_reset_line_in,
    .boot_source_in, .input_clock_divide_select, .dll_ratio, .hard_reset_line_out, .hard_reset_line_oe,
    .soft_reset_line_out, .soft_reset_line_oe, .strap_oe, .boot_source, .clock_divide_latched,
    .internal_reset, .pll_locked, .dll_locked, .bus_tick);
  reset_board_model u_board (.clk, .host_mode, .por_req, .ext_hard, .ext_soft, .hard_reset_line_oe,
    .soft_reset_line_oe, .primary_clock_tick, .bus_sync_tick, .power_on_reset_line_n, .hard_reset_line_in,
    .soft_reset_line_in);
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Monitor: pops the oldest strap note at each lock, measures tick spacing of the releases
  always @(posedge clk) begin
    cycles++;
    if (rst === 1'b0) begin
      if (pll_locked === 1'b1 && !pll_d) begin
        exp_v = exp_q.pop_front();
        `CHECK("straps", exp_v, {clock_divide_latched, boot_source})
      end
      if (hard_d && hard_reset_line_oe === 1'b0) `CHECK("hold", 1'b1, hold inside {[512:514]})
      if (soft_d && soft_reset_line_oe === 1'b0) `CHECK("gap", 1'b1, gap inside {[16:18]})
      hold = (dll_locked === 1'b1 && !dll_d) ? 0 : hold + int'(bus_tick === 1'b1);
      gap = (hard_reset_line_oe === 1'b1) ? 0 : gap + int'(bus_tick === 1'b1);
    end
    pll_d = (pll_locked === 1'b1);
    dll_d = (dll_locked === 1'b1);
    hard_d = (hard_reset_line_oe === 1'b1);
    soft_d = (soft_reset_line_oe === 1'b1);
    if (cycles > 60000) begin
      fails++;
      stop_test();
    end
  end
  task automatic wait_done();
    int n;
    n = 0;
    while (!(dll_locked === 1'b1 && soft_reset_line_oe === 1'b0) && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000) fails++;
    #1 `CHECK("settled", 5'h10, {strap_oe, internal_reset, hard_reset_line_oe, hard_reset_line_out, soft_reset_line_out})
  endtask : wait_done
  task automatic run_por(input logic h, input logic [3:0] st, input logic [3:0] r);
    @(posedge clk);
    #1 por_req = 1;
    host_mode = h;
    {input_clock_divide_select, boot_source_in} = st;
    dll_ratio = r;
    last = st;
    exp_q.push_back(st);
    repeat (10) @(posedge clk);
    #1 por_req = 0;
    wait_done();
  endtask : run_por
  task automatic pulse(input logic hard, input int n);
    @(posedge clk);
    #1 {ext_hard, ext_soft} = hard ? 2'b10 : 2'b01;
    repeat (n) begin
      @(posedge clk);
      while (bus_tick !== 1'b1) @(posedge clk);
    end
    #1 {ext_hard, ext_soft} = 2'b00;
    repeat (8) @(posedge clk);
  endtask : pulse
  initial begin
    void'($urandom(52824));
    repeat (4) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 4; i++) run_por(i[0], 4'($urandom), 4'(2 * $urandom_range(1, 4)));
    pulse(1'b1, 10);
    `CHECK("short pulse", 2'b00, {hard_reset_line_oe, internal_reset})
    exp_q.push_back(last);
    pulse(1'b0, 40);
    wait_done();
    stop_test();
  end
endmodule : reset_init_sequencer_test
`default_nettype wire
